// ===== verilog/lpm_consts.svh
// Register offsets, field positions, reset values and warm-up counts
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH

`define LPM_ADDR_W          8
`define LPM_OFS_HALT_CTRL   8'h38
`define LPM_OFS_CLK_MODE    8'h3C
`define LPM_OFS_BT_CTRL     8'h40
`define LPM_OFS_INT_CTRL    8'h44
`define LPM_OFS_STATUS      8'h48
// Marks a write address outside the map
`define LPM_OFS_NONE        8'hFC

`define LPM_HMC_START       7
`define LPM_HMC_RELEASE_METHOD        6
`define LPM_HMC_RETURN_MODE_SELECT        5
`define LPM_HMC_HOLD        4
`define LPM_HMC_WUT_HI      3
`define LPM_HMC_WUT_LO      2
`define LPM_HMC_RESET       8'h00
`define LPM_HMC_READ_MASK   8'hFC

`define LPM_CMC_SEL_LOW     0
`define LPM_CMC_HIGH_OSC    1
`define LPM_CMC_LOW_OSC     2
`define LPM_CMC_GATE_HALT   3
`define LPM_CMC_RESET       4'h2

`define LPM_BTC_SEL_HI      2
`define LPM_BTC_SEL_LO      0
`define LPM_BTC_EN          3
`define LPM_BTC_RESET       4'h0

`define LPM_INT_MIE         0
`define LPM_INT_TIE         1
`define LPM_INT_LATCH       2

`define LPM_RESP_OKAY       2'h0
`define LPM_RESP_DECERR     2'h3

// Warm-up lengths in oscillator periods
`define LPM_WU_FC_00        (3 * (2 ** 16))
`define LPM_WU_FC_01        (2 ** 16)
`define LPM_WU_FC_10        (3 * (2 ** 14))
`define LPM_WU_FC_11        (2 ** 14)
`define LPM_WU_FS_00        (3 * (2 ** 13))
`define LPM_WU_FS_01        (2 ** 13)
`define LPM_WU_FS_10        (3 * (2 ** 6))
`define LPM_WU_FS_11        (2 ** 6)
`define LPM_WU_CNT_W        18

`endif

// ===== verilog/lpm_pkg.sv
// Types shared by the low-power mode controller
package lpm_pkg;

	typedef enum logic [1:0] {
		LPM_RUN,
		LPM_SLEEP,
		LPM_HALT,
		LPM_WARM
	} lpm_mode_e;

	typedef struct packed {
		logic cpu_clk_en;
		logic periph_clk_en;
		logic timer_clk_en;
		logic high_osc_en;
		logic low_osc_en;
	} lpm_gate_s;

	typedef struct packed {
		logic port_hiz;
		logic port_in_zero;
		logic low_clock_run;
	} lpm_port_s;

endpackage

// ===== verilog/lpm_sync_edge.sv
// Two-stage synchroniser with edge detection for a bundle of inputs
`timescale 1ns/1ns
module lpm_sync_edge #(
	parameter int WIDTH = 1
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] prev_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise  = sync_reg & ~prev_reg;
	assign fall  = ~sync_reg & prev_reg;
endmodule // lpm_sync_edge

// ===== verilog/lpm_controller.sv
// Low-power mode controller: gated sleep, full halt and warm-up
`timescale 1ns/1ns
`include "lpm_consts.svh"

// Behaviour
// R1 - Clock gate halt bit set enters gated sleep; only timer keeps clock.
// R2 - Falling edge of selected timer source clock ends gated sleep.
// R3 - After gated sleep the CPU runs again in low-clock run mode; the code keeps the clock select it had before sleep.
// R4 - Sleep ignores timer enable; interrupt needs master, timer and enable bits.
// R5 - Sleep entered with timer enabled sets timer interrupt latch on wake.
// R6 - Full halt stops oscillators and operation, keeping internal state.
// R7 - Halt control bit 7 written one starts full halt.
// R8 - Bit 6 chooses edge (0) or level (1) release by the pin.
// R9 - Execution resumes after warm-up at the following instruction.
// R10 - Bit 5 picks return to high-clock (0) or low-clock (1) run.
// R11 - Bit 4 zero floats port outputs in halt, one keeps them driven.
// R12 - Two-bit field selects one of four warm-up lengths per return clock.
// R13 - Software sets return bit to match the run mode before halting.
// R14 - Reset pin release of halt always returns to high-clock run.
// R15 - Bits 1 and 0 of halt control read as undefined.
// R16 - Halt with hold bit zero forces port inputs to zero.
// R17 - Software uses level release whenever key wakeup inputs serve.
// R18 - Shared release pin floats during halt regardless of hold bit.
// R19 - Leaving gated sleep clears the clock gate halt bit.
// R20 - Software never sets idle and clock gate halt together.
// R21 - Edge release leaves halt on a rising edge of the pin.
// R22 - Return to low-clock run turns on only the low oscillator.
// R23 - CPU stays halted with clocks gated for the whole warm-up.
module lpm_controller #(
	parameter int TIMER_TAPS = 8,
	parameter int WU_SHIFT   = 0
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [31:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [31:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              high_freq_clock,
	input  wire logic              low_freq_clock,
	input  wire logic [TIMER_TAPS-1:0] timer_src_clocks,
	input  wire logic              reset_pin_n,
	input  wire logic              release_pin_i,
	input  wire logic              release_pin_drive_val,
	input  wire logic              release_pin_drive_en,
	output logic                   release_pin_o,
	output logic                   release_pin_oe_n,
	output lpm_pkg::lpm_gate_s     gates,
	output lpm_pkg::lpm_port_s     port_ctrl,
	output logic                   base_timer_irq
);
	import lpm_pkg::*;

	localparam int SEL_W = $clog2(TIMER_TAPS);
	localparam int CNT_W = `LPM_WU_CNT_W;

	if (TIMER_TAPS < 2 || TIMER_TAPS > 8)
		$error("TIMER_TAPS must be 2 to 8");
	if (WU_SHIFT < 0 || WU_SHIFT > 6)
		$error("WU_SHIFT must be 0 to 6");

	lpm_mode_e        mode_reg;
	logic [7:0]       halt_ctrl_reg;
	logic [3:0]       clk_mode_reg;
	logic [3:0]       bt_ctrl_reg;
	logic             mie_reg;
	logic             tie_reg;
	logic             bt_latch_reg;
	logic             sleep_bten_reg;
	logic             ret_low_reg;
	logic [CNT_W-1:0] warm_cnt_reg;
	logic             aw_hold_reg;
	logic             w_hold_reg;
	logic [7:0]       awaddr_reg;
	logic [7:0]       wdata_reg;
	logic             wstrb0_reg;
	logic             bvalid_reg;
	logic [1:0]       bresp_reg;
	logic             rvalid_reg;
	logic [1:0]       rresp_reg;
	logic [31:0]      rdata_reg;
	logic [31:0]      rd_data;
	logic             rd_hit;
	logic             wr_fire;
	logic             wr_map;
	logic             wr_halt;
	logic             wr_clk;
	logic             wr_bt;
	logic             wr_int;
	logic [1:0]       osc_lvl;
	logic [1:0]       osc_rise;
	logic [1:0]       pin_lvl;
	logic [1:0]       pin_rise;
	logic [TIMER_TAPS-1:0] tap_fall;
	logic             halt_go;
	logic             sleep_go;
	logic             sleep_wake;
	logic             rst_pin_low;
	logic             rel_ok;
	logic             warm_enter;
	logic             warm_ret_low;
	logic             warm_done;
	logic             warm_tick;
	logic             halted;

	// Oscillators, pins and timer taps come from outside this clock
	lpm_sync_edge #(.WIDTH(2)) u_osc_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({low_freq_clock, high_freq_clock}),
		.level    (osc_lvl),
		.rise     (osc_rise),
		.fall     ()
	);

	lpm_sync_edge #(.WIDTH(2)) u_pin_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({~reset_pin_n, release_pin_i}),
		.level    (pin_lvl),
		.rise     (pin_rise),
		.fall     ()
	);

	lpm_sync_edge #(.WIDTH(TIMER_TAPS)) u_tap_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (timer_src_clocks),
		.level    (),
		.rise     (),
		.fall     (tap_fall)
	);

	function automatic logic [CNT_W-1:0] warm_len(input logic [1:0] warmup_select, input logic low);
		int n;
		case ({low, warmup_select})
			3'b000:  n = `LPM_WU_FC_00;
			3'b001:  n = `LPM_WU_FC_01;
			3'b010:  n = `LPM_WU_FC_10;
			3'b011:  n = `LPM_WU_FC_11;
			3'b100:  n = `LPM_WU_FS_00;
			3'b101:  n = `LPM_WU_FS_01;
			3'b110:  n = `LPM_WU_FS_10;
			default: n = `LPM_WU_FS_11;
		endcase
		return CNT_W'(n >> WU_SHIFT);
	endfunction

	// Mode events
	assign rst_pin_low  = pin_lvl[1];
	assign halted       = (mode_reg == LPM_HALT) || (mode_reg == LPM_WARM);
	assign halt_go      = (mode_reg == LPM_RUN) && halt_ctrl_reg[`LPM_HMC_START]; // R7
	assign sleep_go     = (mode_reg == LPM_RUN) && !halt_ctrl_reg[`LPM_HMC_START]
		&& clk_mode_reg[`LPM_CMC_GATE_HALT]; // R1 R4
	assign sleep_wake   = (mode_reg == LPM_SLEEP)
		&& tap_fall[bt_ctrl_reg[SEL_W-1:0]]; // R2 R4
	assign rel_ok       = halt_ctrl_reg[`LPM_HMC_RELEASE_METHOD] ? pin_lvl[0] : pin_rise[0]; // R8 R21
	assign warm_enter   = (halt_go && halt_ctrl_reg[`LPM_HMC_RELEASE_METHOD] && pin_lvl[0])
		|| ((mode_reg == LPM_HALT) && (rst_pin_low || rel_ok));
	assign warm_ret_low = (mode_reg == LPM_HALT && rst_pin_low) ? 1'b0
		: halt_ctrl_reg[`LPM_HMC_RETURN_MODE_SELECT]; // R10 R14
	assign warm_tick    = ret_low_reg ? osc_rise[1] : osc_rise[0];
	assign warm_done    = (mode_reg == LPM_WARM) && (warm_cnt_reg == '0); // R23

	// Operating mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= LPM_RUN;
		end else begin
			case (mode_reg)
				LPM_RUN: begin
					if (warm_enter)
						mode_reg <= LPM_WARM;
					else if (halt_go)
						mode_reg <= LPM_HALT; // R6
					else if (sleep_go)
						mode_reg <= LPM_SLEEP;
				end
				LPM_SLEEP: begin
					if (sleep_wake)
						mode_reg <= LPM_RUN; // R3
				end
				LPM_HALT: begin
					if (warm_enter)
						mode_reg <= LPM_WARM;
				end
				LPM_WARM: begin
					if (warm_done)
						mode_reg <= LPM_RUN; // R9 R23
				end
				default: mode_reg <= LPM_RUN;
			endcase
		end
	end

	// Warm-up counter, counted in periods of the returning oscillator
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			warm_cnt_reg <= '0;
			ret_low_reg  <= 1'b0;
		end else if (warm_enter) begin
			warm_cnt_reg <= warm_len(halt_ctrl_reg[`LPM_HMC_WUT_HI:`LPM_HMC_WUT_LO],
				warm_ret_low); // R12
			ret_low_reg  <= warm_ret_low;
		end else if (mode_reg == LPM_WARM && warm_tick && warm_cnt_reg != '0) begin
			warm_cnt_reg <= warm_cnt_reg - CNT_W'(1);
		end
	end

	// Halt-mode control register; start bit drops when execution resumes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			halt_ctrl_reg <= `LPM_HMC_RESET;
		end else if (wr_halt) begin
			halt_ctrl_reg <= wdata_reg;
		end else if (warm_done) begin
			halt_ctrl_reg[`LPM_HMC_START] <= 1'b0; // R9
		end
	end

	// Clock mode control: clock select, oscillators, gate halt bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_mode_reg <= `LPM_CMC_RESET;
		end else if (warm_done) begin
			clk_mode_reg[`LPM_CMC_SEL_LOW]  <= ret_low_reg; // R10 R14
			clk_mode_reg[`LPM_CMC_HIGH_OSC] <= !ret_low_reg; // R22
			if (ret_low_reg)
				clk_mode_reg[`LPM_CMC_LOW_OSC] <= 1'b1; // R22
		end else if (sleep_wake) begin
			clk_mode_reg[`LPM_CMC_GATE_HALT] <= 1'b0; // R19
		end else if (wr_clk) begin
			clk_mode_reg <= wdata_reg[3:0];
		end
	end

	// Base timer control
	always_ff @(posedge aclk) begin
		if (!aresetn)
			bt_ctrl_reg <= `LPM_BTC_RESET;
		else if (wr_bt)
			bt_ctrl_reg <= wdata_reg[3:0];
	end

	// Timer interrupt latch; a wake event beats a software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mie_reg        <= 1'b0;
			tie_reg        <= 1'b0;
			bt_latch_reg   <= 1'b0;
			sleep_bten_reg <= 1'b0;
		end else begin
			if (sleep_go)
				sleep_bten_reg <= bt_ctrl_reg[`LPM_BTC_EN]; // R5
			if (wr_int) begin
				mie_reg <= wdata_reg[`LPM_INT_MIE];
				tie_reg <= wdata_reg[`LPM_INT_TIE];
			end
			if (sleep_wake && sleep_bten_reg)
				bt_latch_reg <= 1'b1; // R5
			else if (wr_int && wdata_reg[`LPM_INT_LATCH])
				bt_latch_reg <= 1'b0;
		end
	end

	// Clock gates, oscillators, ports and the shared release pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gates            <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
			port_ctrl        <= '0;
			release_pin_o    <= 1'b0;
			release_pin_oe_n <= 1'b1;
			base_timer_irq   <= 1'b0;
		end else begin
			gates.cpu_clk_en    <= (mode_reg == LPM_RUN); // R1 R23
			gates.periph_clk_en <= (mode_reg == LPM_RUN); // R1 R6
			gates.timer_clk_en  <= (mode_reg == LPM_RUN) || (mode_reg == LPM_SLEEP); // R1
			case (mode_reg)
				LPM_HALT: begin
					gates.high_osc_en <= 1'b0; // R6
					gates.low_osc_en  <= 1'b0;
				end
				LPM_WARM: begin
					gates.high_osc_en <= !ret_low_reg; // R22
					gates.low_osc_en  <= ret_low_reg || clk_mode_reg[`LPM_CMC_LOW_OSC];
				end
				default: begin
					gates.high_osc_en <= clk_mode_reg[`LPM_CMC_HIGH_OSC];
					gates.low_osc_en  <= clk_mode_reg[`LPM_CMC_LOW_OSC];
				end
			endcase
			port_ctrl.port_hiz      <= halted && !halt_ctrl_reg[`LPM_HMC_HOLD]; // R11
			port_ctrl.port_in_zero  <= halted && !halt_ctrl_reg[`LPM_HMC_HOLD]; // R16
			port_ctrl.low_clock_run <= clk_mode_reg[`LPM_CMC_SEL_LOW]; // R3
			release_pin_o           <= release_pin_drive_val;
			release_pin_oe_n        <= halted || !release_pin_drive_en; // R18
			base_timer_irq <= bt_latch_reg && mie_reg && tie_reg
				&& bt_ctrl_reg[`LPM_BTC_EN]; // R4
		end
	end

	// AXI4-Lite write channel: address and data taken in either order
	assign s_axi_awready = !aw_hold_reg;
	assign s_axi_wready  = !w_hold_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign wr_map  = (awaddr_reg == `LPM_OFS_HALT_CTRL) || (awaddr_reg == `LPM_OFS_CLK_MODE)
		|| (awaddr_reg == `LPM_OFS_BT_CTRL) || (awaddr_reg == `LPM_OFS_INT_CTRL);
	assign wr_halt = wr_fire && wstrb0_reg && (awaddr_reg == `LPM_OFS_HALT_CTRL);
	assign wr_clk  = wr_fire && wstrb0_reg && (awaddr_reg == `LPM_OFS_CLK_MODE);
	assign wr_bt   = wr_fire && wstrb0_reg && (awaddr_reg == `LPM_OFS_BT_CTRL);
	assign wr_int  = wr_fire && wstrb0_reg && (awaddr_reg == `LPM_OFS_INT_CTRL);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			awaddr_reg  <= '0;
			wdata_reg   <= '0;
			wstrb0_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `LPM_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_hold_reg) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg  <= (s_axi_awaddr[31:8] == '0)
					? {s_axi_awaddr[7:2], 2'b00} : `LPM_OFS_NONE;
			end
			if (s_axi_wvalid && !w_hold_reg) begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_map ? `LPM_RESP_OKAY : `LPM_RESP_DECERR;
				aw_hold_reg <= 1'b0;
				w_hold_reg  <= 1'b0;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel
	always_comb begin
		rd_hit  = 1'b1;
		rd_data = '0;
		case ({s_axi_araddr[7:2], 2'b00})
			`LPM_OFS_HALT_CTRL: rd_data[7:0] = halt_ctrl_reg & `LPM_HMC_READ_MASK; // R15
			`LPM_OFS_CLK_MODE:  rd_data[3:0] = clk_mode_reg;
			`LPM_OFS_BT_CTRL:   rd_data[3:0] = bt_ctrl_reg;
			`LPM_OFS_INT_CTRL:  rd_data[2:0] = {bt_latch_reg, tie_reg, mie_reg};
			`LPM_OFS_STATUS:    rd_data[1:0] = mode_reg;
			default:            rd_hit = 1'b0;
		endcase
		if (s_axi_araddr[31:8] != '0)
			rd_hit = 1'b0;
	end

	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= `LPM_RESP_OKAY;
			rdata_reg  <= '0;
		end else if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_hit ? rd_data : '0;
			rresp_reg  <= rd_hit ? `LPM_RESP_OKAY : `LPM_RESP_DECERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end
endmodule // lpm_controller

// ===== verif/lpm_controller_props.sv
// Port-level assertions for the low-power mode controller
`timescale 1ns/1ns
module lpm_props (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              release_pin_oe_n,
	input wire lpm_pkg::lpm_gate_s gates,
	input wire lpm_pkg::lpm_port_s port_ctrl
);
	import lpm_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	wr_answer_a: assert property (wr_both |-> ##2 s_axi_bvalid)
		else $error("write response late");
	rd_answer_a: assert property (ar_take |=> s_axi_rvalid)
		else $error("read data late");
	rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data not released");
	pin_float_a: assert property (!gates.timer_clk_en |-> release_pin_oe_n)
		else $error("release pin driven while halted");
	sleep_gate_a: assert property (!gates.cpu_clk_en && gates.timer_clk_en |-> !gates.periph_clk_en)
		else $error("peripheral clock running in gated sleep");
	port_pair_a: assert property (port_ctrl.port_hiz == port_ctrl.port_in_zero)
		else $error("port float and input force disagree");
endmodule // lpm_props

bind lpm_controller lpm_props u_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.release_pin_oe_n(release_pin_oe_n), .gates(gates), .port_ctrl(port_ctrl));

// ===== verif/lpm_far_side.sv
// Oscillators, timer taps and release pin outside the controller
`timescale 1ns/1ns
module lpm_far_side (
	input wire logic        aclk,
	input wire logic        pin_req,
	input wire logic        dut_oe_n,
	input wire logic        dut_pin,
	input wire logic [1:0]  osc_en,
	output logic            fc,
	output logic            fs,
	output logic [7:0]      taps,
	output logic            pin
);
	logic [15:0] cnt_reg;
	initial cnt_reg = 16'h0000;
	always @(posedge aclk) begin
		cnt_reg <= cnt_reg + 16'h0001;
	end
	// Oscillators run only while enabled: fc period 4, fs period 16 cycles
	assign fc = cnt_reg[1] && osc_en[1];
	assign fs = cnt_reg[3] && osc_en[0];
	assign taps = cnt_reg[11:4];
	// Shared pin: outside world drives only when the controller floats it
	assign pin = dut_oe_n ? pin_req : dut_pin;
	// No key wakeup inputs are offered as release sources
endmodule // lpm_far_side

// ===== verif/lpm_controller_tb.sv
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ns
module lpm_controller_tb;
	import lpm_pkg::*;
	localparam int HMC = 32'h0000_0038;
	localparam int CMC = 32'h0000_003c;
	localparam int BTC = 32'h0000_0040;
	localparam int INTC = 32'h0000_0044;
	localparam int STAT = 32'h0000_0048;
	localparam logic [1:0] OK = 2'h0;
	localparam logic [1:0] DEC = 2'h3;
	logic        aclk, aresetn, awvalid, wvalid, arvalid, awready, wready, bvalid;
	logic        arready, rvalid, irq, rst_pin_n, pin_req, drv_val, pin, pin_o, oe_n, fc, fs;
	logic        bready, rready;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [7:0]  taps;
	lpm_gate_s   gates;
	lpm_port_s   port_ctrl;
	int          failures, samples_checked;

	lpm_controller #(.TIMER_TAPS(8), .WU_SHIFT(6)) u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.high_freq_clock(fc), .low_freq_clock(fs), .timer_src_clocks(taps),
		.reset_pin_n(rst_pin_n), .release_pin_i(pin), .release_pin_drive_val(drv_val),
		.release_pin_drive_en(1'b1), .release_pin_o(pin_o), .release_pin_oe_n(oe_n),
		.gates(gates), .port_ctrl(port_ctrl), .base_timer_irq(irq));

	lpm_far_side u_far (.aclk(aclk), .pin_req(pin_req), .dut_oe_n(oe_n), .dut_pin(pin_o),
		.osc_en({gates.high_osc_en, gates.low_osc_en}),
		.fc(fc), .fs(fs), .taps(taps), .pin(pin));

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			failures++;
			$display("mismatch at %0t: wait ran out", $time);
			wrap_up();
		end
	endtask

	task automatic wr(input int a, input int d, input logic [1:0] er);
		int n;
		logic ad, wd;
		n = 0;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= 32'(a);
		wdata <= 32'(d);
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && wd) && n < 100) begin
			@(posedge aclk);
			n++;
			if (!ad && awready) begin
				awvalid <= 1'b0;
				ad = 1'b1;
			end
			if (!wd && wready) begin
				wvalid <= 1'b0;
				wd = 1'b1;
			end
		end
		repeat ($urandom % 3) @(posedge aclk);
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (!bvalid && n < 100);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er));
		tmo(n, 100);
	endtask

	task automatic rd(input int a, input int e, input logic [1:0] er);
		int n;
		n = 0;
		araddr <= 32'(a);
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (!arready && n < 100);
		arvalid <= 1'b0;
		repeat ($urandom % 3) @(posedge aclk);
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (!rvalid && n < 100);
		rready <= 1'b0;
		chk(rdata, 32'(e));
		chk(32'(rresp), 32'(er));
		tmo(n, 100);
	endtask

	task automatic wait_cpu(output int n, input int lim);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (gates.cpu_clk_en !== 1'b1 && n < lim);
		tmo(n, lim);
	endtask

	// Warm-up length in aclk cycles for the bench's oscillator periods
	function automatic int wu_len(input int warmup_select, input int lo);
		int b;
		b = lo ? (warmup_select < 2 ? 13 : 6) : (warmup_select < 2 ? 16 : 14);
		return ((warmup_select % 2) ? 1 : 3) * (1 << b) / 64 * (lo ? 16 : 4);
	endfunction

	initial begin
		int k, sel, hm, release_method, return_mode_select, hold, warmup_select, lo, n, e, per;
		failures = 0;
		samples_checked = 0;
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		bready = 1'b0;
		rready = 1'b0;
		awaddr = 32'h0000_0000;
		wdata = 32'h0000_0000;
		araddr = 32'h0000_0000;
		wstrb = 4'h0;
		rst_pin_n = 1'b1;
		pin_req = 1'b0;
		drv_val = 1'b0;
		void'($urandom(32'h1c20_1151));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(32'(gates), 32'h0000_001e);
		rd(HMC, 0, OK);
		for (k = 0; k < 4; k++) begin
			hm = $urandom % 128;
			wr(HMC, hm, OK);
			rd(HMC, hm & 32'h0000_00fc, OK);
		end
		wr(HMC, 0, OK);
		rd(32'h0000_0080, 0, DEC);
		wr(STAT, 1, DEC);
		$display("test registers done");
		for (k = 0; k < 2; k++) begin
			sel = 4 + $urandom % 4;
			wr(BTC, k * 8 + sel, OK);
			wr(INTC, 7, OK);
			wr(CMC, 7, OK);
			n = 0;
			while (taps[sel] !== 1'b0 && n < 9000) begin
				@(posedge aclk);
				n++;
			end
			while (taps[sel] !== 1'b1 && n < 9000) begin
				@(posedge aclk);
				n++;
			end
			tmo(n, 9000);
			wr(CMC, 15, OK);
			rd(STAT, 1, OK);
			chk(32'(gates[4:2]), 32'h0000_0001);
			wait_cpu(n, 5000);
			chk(32'(taps[sel]), 32'h0000_0000);
			rd(CMC, 7, OK);
			chk(32'(port_ctrl.low_clock_run), 32'h0000_0001);
			rd(INTC, k ? 7 : 3, OK);
			chk(32'(irq), 32'(k));
		end
		wr(CMC, 2, OK);
		$display("test gated sleep done");
		for (k = 0; k < 9; k++) begin
			release_method = k % 2;
			warmup_select = k % 4;
			return_mode_select = (k > 3);
			hold = (k / 2) % 2;
			lo = return_mode_select && k < 8;
			hm = 128 + release_method * 64 + return_mode_select * 32 + hold * 16 + warmup_select * 4 + 3;
			wr(CMC, return_mode_select ? 7 : 2, OK);
			drv_val <= (release_method == 0);
			pin_req <= (release_method == 0);
			repeat (6) @(posedge aclk);
			chk(32'({pin_o, oe_n}), 32'({release_method == 0, 1'b0}));
			wr(HMC, hm, OK);
			repeat (20) @(posedge aclk);
			rd(STAT, 2, OK);
			chk(32'({gates, oe_n, port_ctrl.port_hiz, port_ctrl.port_in_zero}),
				32'({5'h00, 1'b1, hold == 0, hold == 0}));
			if (k == 8) begin
				rst_pin_n <= 1'b0;
				repeat (8) @(posedge aclk);
				rst_pin_n <= 1'b1;
			end else begin
				if (release_method == 0) begin
					pin_req <= 1'b0;
					repeat (8) @(posedge aclk);
				end
				pin_req <= 1'b1;
			end
			wait_cpu(n, 20000);
			e = wu_len(warmup_select, lo);
			per = lo ? 16 : 4;
			chk(32'(n >= e - per - 8 && n <= e + per + 12), 32'h0000_0001);
			rd(HMC, hm & 32'h0000_007c, OK);
			chk(32'({port_ctrl.low_clock_run, gates.high_osc_en, gates.low_osc_en}),
				32'({lo[0], !lo[0], return_mode_select[0]}));
		end
		drv_val <= 1'b1;
		repeat (6) @(posedge aclk);
		wr(HMC, 32'h0000_00cc, OK);
		rd(STAT, 3, OK);
		wait_cpu(n, 20000);
		rd(HMC, 32'h0000_004c, OK);
		$display("test full halt done");
		wrap_up();
	end
endmodule // lpm_controller_tb
